// ---- pcr_pkg.sv ----
// Constants and types for the counter array register slice
`default_nettype none

package pcr_pkg;

    // ************************************************
    // Sizes and reset values
    // ************************************************
    localparam int PCR_MODULES = 6;
    localparam int PCR_WDOG_MODULE = 5;
    localparam int PCR_CMP_EN_BIT = 6;
    localparam logic [7:0] PCR_BYTE_RST = 8'h00;
    localparam logic [15:0] PCR_WORD_RST = 16'h0000;
    localparam logic [15:0] PCR_CNT_STEP = 16'h0001;

    // ************************************************
    // Register addresses
    // ************************************************
    localparam logic [7:0] PCR_CNT_LO_ADDR = 8'hf9;
    localparam logic [7:0] PCR_CNT_HI_ADDR = 8'hfa;
    localparam logic [7:0] PCR_CPL_ADDR [PCR_MODULES] =
        '{8'hfb, 8'he9, 8'heb, 8'hed, 8'hfd, 8'hd2};
    localparam logic [7:0] PCR_CPH_ADDR [PCR_MODULES] =
        '{8'hfc, 8'hea, 8'hec, 8'hee, 8'hfe, 8'hd3};
    localparam logic [7:0] PCR_MODE_ADDR [PCR_MODULES] =
        '{8'hda, 8'hdb, 8'hdc, 8'hdd, 8'hde, 8'hce};

    // ************************************************
    // Types
    // ************************************************
    typedef logic [15:0] pcr_word_t;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } pcr_sfr_req_t;

endpackage : pcr_pkg

`default_nettype wire

// ---- pcr_regs.sv ----
// Counter array register slice: counter bytes, snapshot, module values
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - Counter low byte readable and writable
// - Low byte writes ignored while watchdog on
// - Counter high byte at own address
// - High byte reads return low-read snapshot
// - High byte writes ignored while watchdog on
// - Module low byte readable and writable
// - Low address also reaches reload low byte
// - Module low write clears comparator enable
// - Module high byte readable and writable
// - High address also reaches reload high byte
// - Module high write sets comparator enable
// - Reload select picks value or reload
// - Comparator enable bit turns comparator on
// - Module 5 mode locked while watchdog on
module pcr_regs
    import pcr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire pcr_sfr_req_t sfr_req,
    input wire logic count_tick,
    input wire logic auto_reload_select,
    input wire logic watchdog_enable_lock,
    output logic [7:0] sfr_rdata,
    output logic [15:0] array_counter_value,
    output logic [PCR_MODULES-1:0][15:0] module_compare_value,
    output logic [PCR_MODULES-1:0][15:0] module_reload_value,
    output logic [PCR_MODULES-1:0][7:0] module_mode,
    output logic [PCR_MODULES-1:0] comparator_function_enable
);

    default clocking dclk @(posedge sys_clk);
    endclocking

    default disable iff (!rstn);

    // ************************************************
    // Storage and decode
    // ************************************************
    pcr_word_t cnt;
    logic [7:0] snap;
    pcr_word_t cap [PCR_MODULES];
    pcr_word_t reload [PCR_MODULES];
    logic [7:0] mode [PCR_MODULES];
    logic [PCR_MODULES-1:0] cpl_hit;
    logic [PCR_MODULES-1:0] cph_hit;
    logic [PCR_MODULES-1:0] mode_hit;
    logic lo_hit;
    logic hi_hit;
    logic cnt_lo_wr;
    logic cnt_hi_wr;
    logic [7:0] next_rdata;

    assign lo_hit = (sfr_req.addr == PCR_CNT_LO_ADDR);
    assign hi_hit = (sfr_req.addr == PCR_CNT_HI_ADDR);

    assign cnt_lo_wr = sfr_req.wr && lo_hit && !watchdog_enable_lock;

    assign cnt_hi_wr = sfr_req.wr && hi_hit && !watchdog_enable_lock;

    assign array_counter_value = cnt;

    // ************************************************
    // Free-running counter
    // ************************************************
    // Low byte write, then high byte write, then count
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cnt <= PCR_WORD_RST;
        end
        else if (cnt_lo_wr)
        begin
            // A software write wins over a count in the same cycle
            cnt[7:0] <= sfr_req.wdata;
        end
        else if (cnt_hi_wr)
        begin
            cnt[15:8] <= sfr_req.wdata;
        end
        else if (count_tick)
        begin
            cnt <= cnt + PCR_CNT_STEP;
        end
    end

    // ************************************************
    // High byte snapshot
    // ************************************************
    // Snapshot on low read
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            snap <= PCR_BYTE_RST;
        end
        else if (sfr_req.rd && lo_hit)
        begin
            snap <= cnt[15:8];
        end
    end

    // ************************************************
    // Capture/compare modules
    // ************************************************
    genvar gi;
    generate
        for (gi = 0; gi < PCR_MODULES; gi++)
        begin : g_mod
            logic locked;

            assign cpl_hit[gi] = (sfr_req.addr == PCR_CPL_ADDR[gi]);
            assign cph_hit[gi] = (sfr_req.addr == PCR_CPH_ADDR[gi]);
            assign mode_hit[gi] = (sfr_req.addr == PCR_MODE_ADDR[gi]);
            assign locked = (gi == PCR_WDOG_MODULE) && watchdog_enable_lock;

            assign module_compare_value[gi] = cap[gi];
            assign module_reload_value[gi] = reload[gi];
            assign module_mode[gi] = mode[gi];
            assign comparator_function_enable[gi] = mode[gi][PCR_CMP_EN_BIT];

            always_ff @(posedge sys_clk or negedge rstn)
            begin
                if (!rstn)
                begin
                    cap[gi] <= PCR_WORD_RST;
                    reload[gi] <= PCR_WORD_RST;
                end
                else if (sfr_req.wr && cpl_hit[gi])
                begin
                    if (auto_reload_select)
                    begin
                        reload[gi][7:0] <= sfr_req.wdata;
                    end
                    else
                    begin
                        cap[gi][7:0] <= sfr_req.wdata;
                    end
                end
                else if (sfr_req.wr && cph_hit[gi])
                begin
                    if (auto_reload_select)
                    begin
                        reload[gi][15:8] <= sfr_req.wdata;
                    end
                    else
                    begin
                        cap[gi][15:8] <= sfr_req.wdata;
                    end
                end
            end

            always_ff @(posedge sys_clk or negedge rstn)
            begin
                if (!rstn)
                begin
                    mode[gi] <= PCR_BYTE_RST;
                end
                else if (locked)
                begin
                    mode[gi] <= mode[gi];
                end
                else if (sfr_req.wr && mode_hit[gi])
                begin
                    mode[gi] <= sfr_req.wdata;
                end
                else if (sfr_req.wr && cpl_hit[gi])
                begin
                    mode[gi][PCR_CMP_EN_BIT] <= 1'b0;
                end
                else if (sfr_req.wr && cph_hit[gi])
                begin
                    mode[gi][PCR_CMP_EN_BIT] <= 1'b1;
                end
            end

            a_cpl_clears_en: assert property (
                sfr_req.wr && cpl_hit[gi] && !locked
                |=> !comparator_function_enable[gi])
                else $error("module low write left enable set");

            a_cph_sets_en: assert property (
                sfr_req.wr && cph_hit[gi] && !locked
                |=> comparator_function_enable[gi])
                else $error("module high write left enable clear");

            a_reload_route: assert property (
                sfr_req.wr && cpl_hit[gi] && auto_reload_select
                |=> reload[gi][7:0] == $past(sfr_req.wdata)
                && cap[gi] == $past(cap[gi]))
                else $error("reload write misrouted");

            a_value_route: assert property (
                sfr_req.wr && cph_hit[gi] && !auto_reload_select
                |=> cap[gi][15:8] == $past(sfr_req.wdata)
                && reload[gi] == $past(reload[gi]))
                else $error("value write misrouted");
        end
    endgenerate

    // ************************************************
    // Read path
    // ************************************************
    // Unmapped addresses read as zero so other blocks can OR in
    always_comb
    begin
        next_rdata = PCR_BYTE_RST;
        if (lo_hit)
        begin
            next_rdata = cnt[7:0];
        end
        else if (hi_hit)
        begin
            next_rdata = snap;
        end
        for (int i = 0; i < PCR_MODULES; i++)
        begin
            if (cpl_hit[i])
            begin
                next_rdata = auto_reload_select ? reload[i][7:0] : cap[i][7:0];
            end
            else if (cph_hit[i])
            begin
                next_rdata = auto_reload_select ? reload[i][15:8] : cap[i][15:8];
            end
            else if (mode_hit[i])
            begin
                next_rdata = mode[i];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sfr_rdata <= PCR_BYTE_RST;
        end
        else if (sfr_req.rd)
        begin
            sfr_rdata <= next_rdata;
        end
    end

    // ************************************************
    // Checks
    // ************************************************
    sequence s_low_read;
        sfr_req.rd && lo_hit;
    endsequence

    sequence s_high_read;
        sfr_req.rd && hi_hit;
    endsequence

    sequence s_locked_lo_wr;
        sfr_req.wr && lo_hit && watchdog_enable_lock;
    endsequence

    sequence s_locked_hi_wr;
        sfr_req.wr && hi_hit && watchdog_enable_lock;
    endsequence

    a_snap_pair: assert property (s_low_read
        |=> snap == $past(cnt[15:8]) && sfr_rdata == $past(cnt[7:0]))
        else $error("snapshot and low byte disagree");

    a_snap_read: assert property (s_low_read ##1 !sfr_req.rd ##1 s_high_read
        |=> sfr_rdata == $past(cnt[15:8], 3))
        else $error("high read missed snapshot");

    a_snap_hold: assert property (!(sfr_req.rd && lo_hit)
        |=> $stable(snap))
        else $error("snapshot moved without low read");

    a_low_lock: assert property (s_locked_lo_wr
        |=> cnt == $past(cnt) + ($past(count_tick) ? PCR_CNT_STEP : PCR_WORD_RST))
        else $error("locked low byte changed");

    a_high_lock: assert property (s_locked_hi_wr
        |=> cnt == $past(cnt) + ($past(count_tick) ? PCR_CNT_STEP : PCR_WORD_RST))
        else $error("locked high byte changed");

    a_low_write: assert property (cnt_lo_wr
        |=> cnt[7:0] == $past(sfr_req.wdata) && $stable(cnt[15:8]))
        else $error("low byte write lost");

    a_high_write: assert property (cnt_hi_wr
        |=> cnt[15:8] == $past(sfr_req.wdata) && $stable(cnt[7:0]))
        else $error("high byte write lost");

    a_mode5_lock: assert property (watchdog_enable_lock
        |=> module_mode[PCR_WDOG_MODULE] == $past(module_mode[PCR_WDOG_MODULE]))
        else $error("module 5 mode changed while locked");

endmodule : pcr_regs

`default_nettype wire

// ---- pcr_core_model.sv ----
// Processor core model driving the special-function-register bus
`timescale 1ns/100ps
`default_nettype none

module pcr_core_model
    import pcr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic [7:0] sfr_rdata,
    output var pcr_sfr_req_t sfr_req
);
    // ************************************************
    // Bus access
    // ************************************************
    initial sfr_req = '0;

    // One-cycle request, then released fields are scrambled
    // so that stale address or data can never pass for a live one
    task automatic access(input logic [7:0] a, input logic w, input logic [7:0] d, output logic [7:0] q);
        @(negedge sys_clk);
        sfr_req <= '{addr: a, wr: w, rd: !w, wdata: d};
        @(negedge sys_clk);
        q = sfr_rdata;
        sfr_req <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
    endtask : access
endmodule : pcr_core_model

`default_nettype wire

// ---- counter_array_capture_regs_bench.sv ----
// Self-checking testbench for the counter array register slice
`timescale 1ns/100ps
`default_nettype none

module counter_array_capture_regs_bench;
    import pcr_pkg::*;
    // ************************************************
    // Signals and instances
    // ************************************************
    logic sys_clk, rstn, count_tick, auto_reload_select, watchdog_enable_lock;
    pcr_sfr_req_t sfr_req;
    logic [7:0] sfr_rdata, lo, hi, q;
    logic [15:0] array_counter_value;
    logic [PCR_MODULES-1:0][15:0] module_compare_value, module_reload_value;
    logic [PCR_MODULES-1:0][7:0] module_mode;
    logic [PCR_MODULES-1:0] comparator_function_enable;
    int n_errors = 0;
    int samples_checked = 0;

    pcr_regs u_pcr_regs (.sys_clk(sys_clk), .rstn(rstn), .sfr_req(sfr_req), .count_tick(count_tick),
        .auto_reload_select(auto_reload_select), .watchdog_enable_lock(watchdog_enable_lock),
        .sfr_rdata(sfr_rdata), .array_counter_value(array_counter_value),
        .module_compare_value(module_compare_value), .module_reload_value(module_reload_value),
        .module_mode(module_mode), .comparator_function_enable(comparator_function_enable));
    pcr_core_model u_pcr_core_model (.sys_clk(sys_clk), .sfr_rdata(sfr_rdata), .sfr_req(sfr_req));

    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // ************************************************
    // Tasks
    // ************************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_pcr_core_model.access(a, 1'b1, d, q);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        u_pcr_core_model.access(a, 1'b0, 8'h00, q);
        chk({8'h00, q}, {8'h00, exp});
    endtask : rd

    // Counts land on exactly k rising edges
    task automatic tick(input int k);
        count_tick = 1'b1;
        repeat (k) @(negedge sys_clk);
        count_tick = 1'b0;
    endtask : tick

    task automatic conclude();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude

    // ************************************************
    // Tests
    // ************************************************
    initial
    begin
        count_tick = 1'b0;
        auto_reload_select = 1'b0;
        watchdog_enable_lock = 1'b0;
        rstn = 1'b0;
        repeat (12) @(negedge sys_clk);
        rstn = 1'b1;
        for (int n = 0; n < PCR_MODULES; n++)
        begin
            rd(PCR_CPL_ADDR[n], 8'h00);
            rd(PCR_CPH_ADDR[n], 8'h00);
        end
        rd(PCR_CNT_LO_ADDR, 8'h00);
        rd(PCR_CNT_HI_ADDR, 8'h00);
        chk(16'(comparator_function_enable), 16'h0000);
        rd(8'h10, 8'h00);
        // High then low, so both enable edges are seen
        for (int n = 0; n < PCR_MODULES; n++)
        begin
            lo = 8'ha0 + 8'(n);
            hi = 8'h50 + 8'(n);
            wr(PCR_CPH_ADDR[n], hi);
            chk(16'(comparator_function_enable[n]), 16'h0001);
            wr(PCR_CPL_ADDR[n], lo);
            chk(16'(comparator_function_enable[n]), 16'h0000);
            chk(module_compare_value[n], {hi, lo});
            rd(PCR_CPL_ADDR[n], lo);
            rd(PCR_CPH_ADDR[n], hi);
        end
        // Reload pass ends on a high write, so every enable is left set
        auto_reload_select = 1'b1;
        for (int n = 0; n < PCR_MODULES; n++)
        begin
            wr(PCR_CPL_ADDR[n], 8'h3c ^ 8'(n));
            wr(PCR_CPH_ADDR[n], 8'hc3 ^ 8'(n));
            chk(module_reload_value[n], {8'hc3 ^ 8'(n), 8'h3c ^ 8'(n)});
            chk(module_compare_value[n], {8'h50 + 8'(n), 8'ha0 + 8'(n)});
            rd(PCR_CPH_ADDR[n], 8'hc3 ^ 8'(n));
        end
        auto_reload_select = 1'b0;
        rd(PCR_CPL_ADDR[0], 8'ha0);
        // Counter bytes and the high-byte snapshot
        wr(PCR_CNT_LO_ADDR, 8'hfe);
        wr(PCR_CNT_HI_ADDR, 8'h12);
        chk(array_counter_value, 16'h12fe);
        tick(3);
        rd(PCR_CNT_LO_ADDR, 8'h01);
        rd(PCR_CNT_HI_ADDR, 8'h13);
        tick(256);
        chk(array_counter_value, 16'h1401);
        rd(PCR_CNT_HI_ADDR, 8'h13);
        rd(PCR_CNT_LO_ADDR, 8'h01);
        rd(PCR_CNT_HI_ADDR, 8'h14);
        // Watchdog lock; module 5 mode holds 8'h40 from the reload pass
        watchdog_enable_lock = 1'b1;
        wr(PCR_CNT_LO_ADDR, 8'h55);
        wr(PCR_CNT_HI_ADDR, 8'h66);
        chk(array_counter_value, 16'h1401);
        wr(PCR_MODE_ADDR[5], 8'h00);
        chk(16'(module_mode[5]), 16'h0040);
        wr(PCR_CPL_ADDR[5], 8'h77);
        chk(16'(comparator_function_enable[5]), 16'h0001);
        wr(PCR_MODE_ADDR[0], 8'h02);
        chk(16'(module_mode[0]), 16'h0002);
        chk(16'(comparator_function_enable[0]), 16'h0000);
        wr(PCR_MODE_ADDR[0], 8'h42);
        chk(16'(comparator_function_enable[0]), 16'h0001);
        watchdog_enable_lock = 1'b0;
        wr(PCR_CNT_HI_ADDR, 8'h66);
        chk(16'(array_counter_value[15:8]), 16'h0066);
        conclude();
    end

    // Whole sequence takes well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge sys_clk);
        n_errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        conclude();
    end
endmodule : counter_array_capture_regs_bench

`default_nettype wire
